// ==== include/crt_pkg.sv ====
package crt_pkg;

   // ----------------------------------------------------------------
   // bus geometry
   // ----------------------------------------------------------------
   localparam int unsigned CRT_ADDR_W = 12;
   localparam int unsigned CRT_IDX_W  = 8;

   // ----------------------------------------------------------------
   // register indices (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [7:0] CRT_IDX_CONTROL     = 8'hC8;
   localparam logic [7:0] CRT_IDX_MODE        = 8'hC9;
   localparam logic [7:0] CRT_IDX_CAPTURE_LO  = 8'hCA;
   localparam logic [7:0] CRT_IDX_CAPTURE_HI  = 8'hCB;
   localparam logic [7:0] CRT_IDX_COUNT_LO    = 8'hCC;
   localparam logic [7:0] CRT_IDX_COUNT_HI    = 8'hCD;
   localparam logic [7:0] CRT_IDX_CLOCK_CFG   = 8'hD0;
   localparam logic [7:0] CRT_IDX_IRQ_STATUS  = 8'hD1;
   localparam logic [7:0] CRT_IDX_IRQ_CLEAR   = 8'hD2;
   localparam logic [7:0] CRT_IDX_IRQ_ENABLE  = 8'hD3;

   // ----------------------------------------------------------------
   // field layouts
   // ----------------------------------------------------------------
   typedef struct packed {
      logic overflow_flag;           // bit 7
      logic external_event_flag;     // bit 6
      logic rx_clock_select;         // bit 5
      logic tx_clock_select;         // bit 4
      logic external_trigger_enable; // bit 3
      logic run_control;             // bit 2
      logic counter_timer_select;    // bit 1
      logic capture_reload_select;   // bit 0
   } crt_ctrl_t;

   typedef struct packed {
      logic [3:0] unused_hi;          // bits 7..4, read as zero
      logic       capture_auto_clear; // bit 3
      logic [1:0] unused_mid;         // bits 2..1, read as zero
      logic       down_count_enable;  // bit 0
   } crt_mode_t;

   typedef struct packed {
      logic ext_event;  // bit 1
      logic overflow;   // bit 0
   } crt_irq_t;

   typedef enum logic [1:0] {
      CRT_OP_RELOAD  = 2'b00,
      CRT_OP_CAPTURE = 2'b01,
      CRT_OP_UPDOWN  = 2'b10,
      CRT_OP_BAUD    = 2'b11
   } crt_op_t;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [7:0]  CRT_RST_CONTROL   = 8'h00;
   localparam logic [7:0]  CRT_RST_MODE      = 8'h00;
   localparam logic [15:0] CRT_RST_CAPTURE   = 16'h0000;
   localparam logic [15:0] CRT_RST_COUNT     = 16'h0000;
   localparam logic        CRT_RST_FAST      = 1'b0;
   localparam logic [1:0]  CRT_RST_IRQ       = 2'h0;

   // ----------------------------------------------------------------
   // tick dividers, in core clocks per count step
   // ----------------------------------------------------------------
   localparam logic [3:0] CRT_DIV_SLOW = 4'hC;
   localparam logic [3:0] CRT_DIV_FAST = 4'h4;
   localparam logic [3:0] CRT_DIV_BAUD = 4'h2;

   localparam logic [15:0] CRT_COUNT_MAX = 16'hFFFF;

   localparam logic [1:0] CRT_RESP_OKAY   = 2'h0;
   localparam logic [1:0] CRT_RESP_SLVERR = 2'h2;

endpackage : crt_pkg

// ==== src/crt_timer.sv ====
// Contract
// R1: overflow flag sets on 16-bit overflow, or count equals capture when counting down.
// R2: overflow flag set only when both serial clock selects are 0; software sets/clears.
// R3: external flag sets on trigger falling edge or overflow, per mode bits; the code toggles it on up/down overflow or underflow.
// R4: software clears trigger-set external flag; write of 1 or edge raises interrupt.
// R5: serial modes 1/3: receive clock select picks timer 1 or this overflow.
// R6: serial modes 1/3: transmit clock select picks timer 1 or this overflow.
// R7: any serial clock select forces baud mode, auto-reload every overflow.
// R8: outside baud mode, trigger enable makes falling trigger edge capture or reload.
// R9: run control enables counting; clearing it freezes the count.
// R10: counter/timer select picks internal ticks or falling edges of count pin.
// R11: baud mode advances once every 2 clocks regardless of counter/timer select.
// R12: reload select at 0 reloads on overflow and on enabled trigger edge.
// R13: capture select with trigger enable captures count on each falling trigger edge.
// R14: capture auto-clear resets the count after capture.
// R15: down-count enable with trigger pin level sets direction in auto-reload.
// R16: capture registers take count in capture mode, supply reload value otherwise.
// R17: down-count enabled: up while trigger pin high, down while low.
// R18: pin edges found by comparing successive clocked samples.
`timescale 1ns/1ps
`default_nettype none

module crt_timer
   import crt_pkg::*;
(
   input  wire logic                  aclk,                  // core clock, 25 MHz
   input  wire logic                  aresetn,               // synchronous reset, active low
   input  wire logic [CRT_ADDR_W-1:0] s_axi_awaddr,          // write address
   input  wire logic                  s_axi_awvalid,         // write address valid
   output logic                       s_axi_awready,         // write address ready
   input  wire logic [31:0]           s_axi_wdata,           // write data
   input  wire logic [3:0]            s_axi_wstrb,           // write byte enables
   input  wire logic                  s_axi_wvalid,          // write data valid
   output logic                       s_axi_wready,          // write data ready
   output logic [1:0]                 s_axi_bresp,           // write response
   output logic                       s_axi_bvalid,          // write response valid
   input  wire logic                  s_axi_bready,          // write response ready
   input  wire logic [CRT_ADDR_W-1:0] s_axi_araddr,          // read address
   input  wire logic                  s_axi_arvalid,         // read address valid
   output logic                       s_axi_arready,         // read address ready
   output logic [31:0]                s_axi_rdata,           // read data
   output logic [1:0]                 s_axi_rresp,           // read response
   output logic                       s_axi_rvalid,          // read data valid
   input  wire logic                  s_axi_rready,          // read data ready
   input  wire logic                  external_trigger_pin,  // capture/reload trigger pin
   input  wire logic                  external_count_pin,    // external count pin
   input  wire logic [1:0]            serial_mode,           // serial port mode number
   input  wire logic                  timer1_overflow,       // timer 1 overflow pulse
   output logic                       rx_time_base_tick,     // receive bit-rate tick
   output logic                       tx_time_base_tick,     // transmit bit-rate tick
   output logic                       irq                    // level interrupt
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   crt_ctrl_t            ctl;
   crt_ctrl_t            next_ctl;
   crt_mode_t            mode;
   crt_irq_t             irq_status;
   crt_irq_t             irq_enable;
   crt_irq_t             next_irq_status;
   crt_op_t              op;
   logic                 fast_clock_select;
   logic [15:0]          count;
   logic [15:0]          capture;
   logic [3:0]           prescale;
   logic                 trig_now;
   logic                 trig_prev;
   logic                 cnt_now;
   logic                 cnt_prev;
   logic                 aw_hold;
   logic                 w_hold;
   logic [CRT_IDX_W-1:0] aw_idx;
   logic [7:0]           w_byte;
   logic                 w_lane0;

   // ----------------------------------------------------------------
   // pin sampling
   // ----------------------------------------------------------------
   // R18: successive samples
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         trig_now  <= 1'b1;
         trig_prev <= 1'b1;
         cnt_now   <= 1'b1;
         cnt_prev  <= 1'b1;
      end else begin
         trig_now  <= external_trigger_pin;
         trig_prev <= trig_now;
         cnt_now   <= external_count_pin;
         cnt_prev  <= cnt_now;
      end
   end
   logic trig_fall;
   logic cnt_fall;
   assign trig_fall = trig_prev & ~trig_now;
   assign cnt_fall  = cnt_prev & ~cnt_now;

   // ----------------------------------------------------------------
   // operating mode
   // ----------------------------------------------------------------
   logic baud_mode;
   // R7: serial clocks force baud mode
   assign baud_mode = ctl.rx_clock_select | ctl.tx_clock_select;
   assign op        = baud_mode ? CRT_OP_BAUD : ctl.capture_reload_select ? CRT_OP_CAPTURE :
                      mode.down_count_enable ? CRT_OP_UPDOWN : CRT_OP_RELOAD;

   // ----------------------------------------------------------------
   // count rate
   // ----------------------------------------------------------------
   logic [3:0] divide;
   logic       tick;
   logic       advance;
   // R11: baud mode every two clocks
   assign divide = baud_mode ? CRT_DIV_BAUD : (fast_clock_select ? CRT_DIV_FAST : CRT_DIV_SLOW);
   assign tick   = (prescale >= divide - 4'h1);

   // prescaler free-runs so a mode switch never stalls it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prescale <= 4'h0;
      end else if (tick) begin
         prescale <= 4'h0;
      end else begin
         prescale <= prescale + 4'h1;
      end
   end
   // R9: run control gates counting
   // R10: internal ticks or count pin edges
   assign advance = ctl.run_control & ((ctl.counter_timer_select & ~baud_mode) ? cnt_fall : tick);

   // ----------------------------------------------------------------
   // count events
   // ----------------------------------------------------------------
   logic trig_evt;
   logic count_up;
   logic wrap_up;
   logic wrap_down;
   // R8: trigger only with enable
   assign trig_evt  = trig_fall & ctl.external_trigger_enable;
   // R15: direction from down enable
   // R17: trigger level sets direction
   assign count_up  = (op != CRT_OP_UPDOWN) | trig_now;
   assign wrap_up   = advance & count_up & (count == CRT_COUNT_MAX);
   // R1: down count meets capture
   assign wrap_down = advance & ~count_up & (count == capture);

   // ----------------------------------------------------------------
   // register bus, write side
   // ----------------------------------------------------------------
   logic do_write;
   logic wr_ok;
   assign do_write = aw_hold & w_hold & ~s_axi_bvalid;
   assign wr_ok    = do_write & w_lane0;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold       <= 1'b0;
         s_axi_awready <= 1'b1;
         aw_idx        <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_hold       <= 1'b1;
         s_axi_awready <= 1'b0;
         aw_idx        <= s_axi_awaddr[CRT_IDX_W+1:2];
      end else if (do_write) begin
         aw_hold       <= 1'b0;
         s_axi_awready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_hold       <= 1'b0;
         s_axi_wready <= 1'b1;
         w_byte       <= 8'h00;
         w_lane0      <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_hold       <= 1'b1;
         s_axi_wready <= 1'b0;
         w_byte       <= s_axi_wdata[7:0];
         w_lane0      <= s_axi_wstrb[0];
      end else if (do_write) begin
         w_hold       <= 1'b0;
         s_axi_wready <= 1'b1;
      end
   end

   function automatic logic mapped(input logic [CRT_IDX_W-1:0] idx);
      case (idx)
         CRT_IDX_CONTROL, CRT_IDX_MODE, CRT_IDX_CAPTURE_LO, CRT_IDX_CAPTURE_HI,
         CRT_IDX_COUNT_LO, CRT_IDX_COUNT_HI, CRT_IDX_CLOCK_CFG, CRT_IDX_IRQ_STATUS,
         CRT_IDX_IRQ_CLEAR, CRT_IDX_IRQ_ENABLE: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   endfunction : mapped

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= CRT_RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= mapped(aw_idx) ? CRT_RESP_OKAY : CRT_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end
   logic wr_ctl;
   assign wr_ctl = wr_ok & (aw_idx == CRT_IDX_CONTROL);

   // ----------------------------------------------------------------
   // control register and flags
   // ----------------------------------------------------------------
   logic ovf_set;
   logic ext_set;
   logic ext_toggle;
   // R2: no hardware set in baud mode
   assign ovf_set    = (wrap_up | wrap_down) & ~baud_mode;
   // R3: trigger edge sets external flag
   assign ext_set    = trig_evt & (op != CRT_OP_UPDOWN);
   // R3: up/down wrap flips external flag
   assign ext_toggle = (op == CRT_OP_UPDOWN) & (wrap_up | wrap_down);

   always_comb begin
      next_ctl = ctl;
      if (wr_ctl) begin
         next_ctl = crt_ctrl_t'(w_byte);
      end
      // R1: overflow sets flag, wins over a clearing write
      if (ovf_set) begin
         next_ctl.overflow_flag = 1'b1;
      end
      // R4: edge-set flag stays until software clears it
      if (ext_set) begin
         next_ctl.external_event_flag = 1'b1;
      end else if (ext_toggle) begin
         next_ctl.external_event_flag = ~next_ctl.external_event_flag;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctl <= crt_ctrl_t'(CRT_RST_CONTROL);
      end else begin
         ctl <= next_ctl;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode              <= crt_mode_t'(CRT_RST_MODE);
         fast_clock_select <= CRT_RST_FAST;
      end else if (wr_ok) begin
         if (aw_idx == CRT_IDX_MODE) begin
            mode.capture_auto_clear <= w_byte[3];
            mode.down_count_enable  <= w_byte[0];
         end
         if (aw_idx == CRT_IDX_CLOCK_CFG) begin
            fast_clock_select <= w_byte[0];
         end
      end
   end

   // ----------------------------------------------------------------
   // count register
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count <= CRT_RST_COUNT;
      end else if (wr_ok && aw_idx == CRT_IDX_COUNT_LO) begin
         count[7:0] <= w_byte;
      end else if (wr_ok && aw_idx == CRT_IDX_COUNT_HI) begin
         count[15:8] <= w_byte;
      // R14: clear after capture
      end else if (op == CRT_OP_CAPTURE && trig_evt && mode.capture_auto_clear) begin
         count <= 16'h0000;
      // R12: trigger edge reloads
      end else if (op == CRT_OP_RELOAD && trig_evt) begin
         count <= capture;
      end else if (wrap_up) begin
         // R7: baud mode reloads on every overflow
         // R12: reload on overflow
         // R16: capture supplies reload value
         count <= (op == CRT_OP_CAPTURE) ? 16'h0000 : capture;
      end else if (wrap_down) begin
         count <= CRT_COUNT_MAX;
      end else if (advance) begin
         count <= count_up ? count + 16'h0001 : count - 16'h0001;
      end
   end

   // ----------------------------------------------------------------
   // capture register
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         capture <= CRT_RST_CAPTURE;
      end else if (wr_ok && aw_idx == CRT_IDX_CAPTURE_LO) begin
         capture[7:0] <= w_byte;
      end else if (wr_ok && aw_idx == CRT_IDX_CAPTURE_HI) begin
         capture[15:8] <= w_byte;
      // R13: capture on trigger edge
      // R16: capture takes both count bytes
      end else if (op == CRT_OP_CAPTURE && trig_evt) begin
         capture <= count;
      end
   end

   // ----------------------------------------------------------------
   // serial time base
   // ----------------------------------------------------------------
   logic async_mode;
   // modes 1 and 3 are the odd ones
   assign async_mode = serial_mode[0];
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_time_base_tick <= 1'b0;
         tx_time_base_tick <= 1'b0;
      end else begin
         // R5: receive time base
         rx_time_base_tick <= async_mode & (ctl.rx_clock_select ? (wrap_up & baud_mode) : timer1_overflow);
         // R6: transmit time base
         tx_time_base_tick <= async_mode & (ctl.tx_clock_select ? (wrap_up & baud_mode) : timer1_overflow);
      end
   end

   // ----------------------------------------------------------------
   // interrupt status, clear and enable
   // ----------------------------------------------------------------
   crt_irq_t events;
   crt_irq_t clear_mask;
   always_comb begin
      events.overflow  = ovf_set;
      // R4: edge or software write of 1 raises interrupt
      events.ext_event = trig_evt | (wr_ctl & w_byte[6]);
      clear_mask       = (wr_ok && aw_idx == CRT_IDX_IRQ_CLEAR) ? crt_irq_t'(w_byte[1:0]) : crt_irq_t'(2'b00);
      // a new event wins over a clear in the same cycle
      next_irq_status  = (irq_status & ~clear_mask) | events;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_status <= crt_irq_t'(CRT_RST_IRQ);
         irq_enable <= crt_irq_t'(CRT_RST_IRQ);
         irq        <= 1'b0;
      end else begin
         irq_status <= next_irq_status;
         if (wr_ok && aw_idx == CRT_IDX_IRQ_ENABLE) begin
            irq_enable <= crt_irq_t'(w_byte[1:0]);
         end
         irq <= |(next_irq_status & irq_enable);
      end
   end

   // ----------------------------------------------------------------
   // register bus, read side
   // ----------------------------------------------------------------
   logic [CRT_IDX_W-1:0] ar_idx;
   logic [7:0]           rd_byte;
   assign ar_idx = s_axi_araddr[CRT_IDX_W+1:2];
   always_comb begin
      case (ar_idx)
         CRT_IDX_CONTROL:    rd_byte = ctl;
         CRT_IDX_MODE:       rd_byte = mode;
         CRT_IDX_CAPTURE_LO: rd_byte = capture[7:0];
         CRT_IDX_CAPTURE_HI: rd_byte = capture[15:8];
         CRT_IDX_COUNT_LO:   rd_byte = count[7:0];
         CRT_IDX_COUNT_HI:   rd_byte = count[15:8];
         CRT_IDX_CLOCK_CFG:  rd_byte = {7'h00, fast_clock_select};
         CRT_IDX_IRQ_STATUS: rd_byte = {6'h00, irq_status};
         CRT_IDX_IRQ_ENABLE: rd_byte = {6'h00, irq_enable};
         default:            rd_byte = 8'h00;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= CRT_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= {24'h000000, rd_byte};
         s_axi_rresp   <= mapped(ar_idx) ? CRT_RESP_OKAY : CRT_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

endmodule : crt_timer

`default_nettype wire

// ==== verif/crt_timer_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module crt_timer_chk
   import crt_pkg::*;
(
   input wire logic        aclk,             // clock
   input wire logic        aresetn,          // reset
   input wire logic        s_axi_awvalid,    // aw valid
   input wire logic        s_axi_awready,    // aw ready
   input wire logic        s_axi_wvalid,     // w valid
   input wire logic        s_axi_wready,     // w ready
   input wire logic [1:0]  s_axi_bresp,      // b resp
   input wire logic        s_axi_bvalid,     // b valid
   input wire logic        s_axi_bready,     // b ready
   input wire logic        s_axi_arvalid,    // ar valid
   input wire logic        s_axi_arready,    // ar ready
   input wire logic [31:0] s_axi_rdata,      // r data
   input wire logic [1:0]  s_axi_rresp,      // r resp
   input wire logic        s_axi_rvalid,     // r valid
   input wire logic        s_axi_rready,     // r ready
   input wire logic        rx_time_base_tick // rx tick
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
   a_bhold: assert property (p_bhold) else $error("write response dropped");
   property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
   a_rhold: assert property (p_rhold) else $error("read data dropped");
   property p_wlat; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid; endproperty
   a_wlat: assert property (p_wlat) else $error("write response late");
   property p_rlat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   a_rlat: assert property (p_rlat) else $error("read data late");
   property p_arblk; s_axi_rvalid |-> !s_axi_arready; endproperty
   a_arblk: assert property (p_arblk) else $error("second read taken");
   property p_rerr; s_axi_rvalid && s_axi_rresp == CRT_RESP_SLVERR |-> s_axi_rdata == 32'h0; endproperty
   a_rerr: assert property (p_rerr) else $error("error read not zero");
   property p_rup; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
   a_rup: assert property (p_rup) else $error("upper read bits set");
   property p_rxtick; rx_time_base_tick |=> !rx_time_base_tick; endproperty
   a_rxtick: assert property (p_rxtick) else $error("rx tick too long");
endmodule : crt_timer_chk
bind crt_timer crt_timer_chk u_crt_timer_chk (.*);
`default_nettype wire

// ==== verif/crt_far_end.sv ====
`timescale 1ns/1ps
`default_nettype none
module crt_far_end (
   input  wire logic       aclk,    // clock
   input  wire logic       rx_tick, // rx tick
   input  wire logic       tx_tick, // tx tick
   output logic            trig,    // trigger pin
   output logic            cpin,    // count pin
   output logic [1:0]      smode,   // serial mode
   output logic            t1ov     // timer 1 overflow
);
   int rx_n = 0;
   int tx_n = 0;
   int t1_div = 0;
   initial begin
      trig = 1'b1;
      cpin = 1'b1;
      smode = 2'h1;
   end
   always @(posedge aclk) begin
      rx_n <= rx_n + int'(rx_tick);
      tx_n <= tx_n + int'(tx_tick);
      t1_div <= (t1_div == 49) ? 0 : t1_div + 1;
      t1ov <= (t1_div == 49);
   end
   task automatic fall_trig;
      trig <= 1'b0;
      repeat (4) @(posedge aclk);
      trig <= 1'b1;
      repeat (4) @(posedge aclk);
   endtask : fall_trig
   task automatic pulse_count(input int n);
      repeat (n) begin
         cpin <= 1'b0;
         repeat (3) @(posedge aclk);
         cpin <= 1'b1;
         repeat (3) @(posedge aclk);
      end
   endtask : pulse_count
endmodule : crt_far_end
`default_nettype wire

// ==== verif/crt_timer_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module crt_timer_tb import crt_pkg::*; ;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic [CRT_ADDR_W-1:0] awaddr, araddr;
   logic [31:0] wdata;
   logic [3:0]  wstrb;
   wire logic awready, wready, bvalid, arready, rvalid, rx_t, tx_t, irq, trig, cpin, t1ov;
   wire logic [1:0]  bresp, rresp, smode;
   wire logic [31:0] rdata;
   int fails, checked, seed, cyc, n, rx0, tx0;
   logic [7:0] d, e, cap;
   logic [1:0] r;
   crt_timer u_crt_timer (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .external_trigger_pin(trig),
      .external_count_pin(cpin), .serial_mode(smode), .timer1_overflow(t1ov), .rx_time_base_tick(rx_t),
      .tx_time_base_tick(tx_t), .irq(irq));
   crt_far_end u_crt_far_end (.aclk(aclk), .rx_tick(rx_t), .tx_tick(tx_t), .trig(trig), .cpin(cpin),
      .smode(smode), .t1ov(t1ov));
   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end
   task automatic end_sim;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : end_sim
   // hang guard
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails++;
         end_sim();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   function automatic logic [7:0] ctl(input logic ov, ex, rx, tx, en, run, ct, cp);
      crt_ctrl_t c;
      c = '{ov, ex, rx, tx, en, run, ct, cp};
      return c;
   endfunction : ctl
   task automatic wr(input logic [7:0] idx, input logic [7:0] v);
      logic aw, w;
      aw = 1'b0;
      w = 1'b0;
      awaddr <= {2'h0, idx, 2'h0};
      wdata <= {24'h0, v};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw && w)) begin
         @(posedge aclk);
         if (!aw && awready === 1'b1) begin
            aw = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w && wready === 1'b1) begin
            w = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (bvalid !== 1'b1);
      bready <= 1'b0;
      @(posedge aclk);
   endtask : wr
   task automatic rd(input logic [7:0] idx);
      araddr <= {2'h0, idx, 2'h0};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      d = rdata[7:0];
      r = rresp;
      rready <= 1'b0;
      @(posedge aclk);
   endtask : rd
   task automatic rc(input logic [7:0] idx, input logic [7:0] exp);
      rd(idx);
      chk(d, exp);
   endtask : rc
   initial begin
      {fails, checked, cyc, seed} = {32'd0, 32'd0, 32'd0, 32'd38419};
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
      {awaddr, araddr, wdata, wstrb} = {12'h0, 12'h0, 32'h0, 4'hF};
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rc(CRT_IDX_CONTROL, CRT_RST_CONTROL);
      rc(CRT_IDX_MODE, CRT_RST_MODE);
      rd(8'h10);
      chk(8'(r), 8'(CRT_RESP_SLVERR));
      cap = 8'h10 + 8'($random(seed) & 32'h7F);
      wr(CRT_IDX_CAPTURE_HI, cap);
      wr(CRT_IDX_COUNT_HI, 8'hFF);
      wr(CRT_IDX_COUNT_LO, 8'hF8);
      wr(CRT_IDX_CLOCK_CFG, 8'h01);
      wr(CRT_IDX_CONTROL, ctl(0, 0, 0, 0, 0, 1, 0, 0));
      repeat (100) @(posedge aclk);
      rc(CRT_IDX_CONTROL, ctl(1, 0, 0, 0, 0, 1, 0, 0));
      rc(CRT_IDX_COUNT_HI, cap);
      chk(8'(irq), 8'h00);
      wr(CRT_IDX_IRQ_ENABLE, 8'h01);
      chk(8'(irq), 8'h01);
      wr(CRT_IDX_IRQ_CLEAR, 8'h01);
      chk(8'(irq), 8'h00);
      wr(CRT_IDX_CONTROL, 8'h00);
      rd(CRT_IDX_COUNT_LO);
      e = d;
      repeat (40) @(posedge aclk);
      rc(CRT_IDX_COUNT_LO, e);
      wr(CRT_IDX_COUNT_HI, 8'h34);
      wr(CRT_IDX_MODE, 8'h08);
      wr(CRT_IDX_CONTROL, ctl(0, 0, 0, 0, 1, 1, 0, 1));
      u_crt_far_end.fall_trig();
      rc(CRT_IDX_CAPTURE_HI, 8'h34);
      rc(CRT_IDX_COUNT_HI, 8'h00);
      rc(CRT_IDX_CONTROL, ctl(0, 1, 0, 0, 1, 1, 0, 1));
      wr(CRT_IDX_CONTROL, 8'h00);
      wr(CRT_IDX_MODE, 8'h00);
      wr(CRT_IDX_COUNT_LO, 8'h00);
      wr(CRT_IDX_CONTROL, ctl(0, 0, 0, 0, 0, 1, 1, 0));
      n = 3 + ($random(seed) & 7);
      u_crt_far_end.pulse_count(n);
      u_crt_far_end.fall_trig();
      rc(CRT_IDX_COUNT_LO, 8'(n));
      rc(CRT_IDX_CONTROL, ctl(0, 0, 0, 0, 0, 1, 1, 0));
      wr(CRT_IDX_CONTROL, 8'h00);
      wr(CRT_IDX_CAPTURE_HI, 8'hFF);
      wr(CRT_IDX_CAPTURE_LO, 8'hF0);
      wr(CRT_IDX_COUNT_HI, 8'hFF);
      wr(CRT_IDX_COUNT_LO, 8'hF0);
      wr(CRT_IDX_CONTROL, ctl(0, 0, 0, 1, 0, 1, 1, 1));
      rx0 = u_crt_far_end.rx_n;
      tx0 = u_crt_far_end.tx_n;
      repeat (320) @(posedge aclk);
      n = u_crt_far_end.tx_n - tx0;
      chk({7'h0, n >= 9 && n <= 11}, 8'h01);
      n = u_crt_far_end.rx_n - rx0;
      chk({7'h0, n >= 5 && n <= 8}, 8'h01);
      rc(CRT_IDX_CONTROL, ctl(0, 0, 0, 1, 0, 1, 1, 1));
      end_sim();
   end
endmodule : crt_timer_tb
`default_nettype wire
